// [cmp_ctl.sv]
// Purpose: Control and status logic around an analog voltage comparator.
// Assumes: Single clock; the analog core output is asynchronous.
// Notes:   Writes take no wait state; reads hold waitrequest for one cycle.
`timescale 1ns/1ps
`default_nettype none

module cmp_ctl (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [1:0]  avs_response,
    // Analog core
    input  wire logic        cmp_core_out,
    output logic             cmp_power_on,
    output logic      [1:0]  cmp_resp_mode,
    output logic      [1:0]  pos_hyst_sel,
    output logic      [1:0]  neg_hyst_sel,
    // Pins, interrupt and reset source
    output logic             cmp_latched_out,
    output logic             cmp_raw_out,
    output logic             cmp_irq,
    output logic             cmp_reset_src
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic        sync1;
        logic        sync2;
        logic        level;
        logic        en;
        logic        rif;
        logic        fif;
        logic        rie;
        logic        fie;
        logic [1:0]  md;
        logic [1:0]  hyp;
        logic [1:0]  hyn;
        logic [31:0] rdata;
        logic [1:0]  resp;
        logic        rd_done;
    } state_s;

    state_s q, d;

    logic       hit_ctrl;
    logic       hit_mode;
    logic       rise;
    logic       fall;
    logic [7:0] ctrl_val;
    logic [7:0] mode_val;

    assign hit_ctrl = (avs_address == cmp_ctl_pkg::ctrl_addr);
    assign hit_mode = (avs_address == cmp_ctl_pkg::mode_addr);
    assign rise     = q.en & q.sync2 & ~q.level;
    assign fall     = q.en & ~q.sync2 & q.level;

    always_comb begin
        ctrl_val = {q.en, q.sync2, q.rif, q.fif, q.hyp, q.hyn};
        mode_val = {2'h0, q.rie, q.fie, 2'h0, q.md};
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        d = q;
        d.sync1 = cmp_core_out;
        d.sync2 = q.sync1;
        d.level = q.sync2;
        d.resp  = q.resp;
        // Read data is registered, so the first read cycle is a wait state.
        d.rd_done = avs_read & ~q.rd_done;
        if (avs_write) begin
            d.resp = 2'h0;
        end
        if (avs_read && !q.rd_done) begin
            d.resp  = 2'h0;
            d.rdata = 32'h0;
            if (hit_ctrl) begin
                d.rdata[7:0] = ctrl_val;
            end else if (hit_mode) begin
                d.rdata[7:0] = mode_val;
            end else begin
                d.resp = 2'h2;
            end
        end
        if (avs_write && avs_byteenable[0]) begin
            if (hit_ctrl) begin
                d.en  = avs_writedata[cmp_ctl_pkg::en_bit];
                d.hyp = avs_writedata[cmp_ctl_pkg::hyp_lsb +: 2];
                d.hyn = avs_writedata[cmp_ctl_pkg::hyn_lsb +: 2];
                d.rif = avs_writedata[cmp_ctl_pkg::rif_bit];
                d.fif = avs_writedata[cmp_ctl_pkg::fif_bit];
            end else if (hit_mode) begin
                d.rie = avs_writedata[cmp_ctl_pkg::rie_bit];
                d.fie = avs_writedata[cmp_ctl_pkg::fie_bit];
                d.md  = avs_writedata[cmp_ctl_pkg::md_lsb +: 2];
            end
        end
        if (avs_write && !hit_ctrl && !hit_mode) begin
            d.resp = 2'h2;
        end
        // Set beats a simultaneous software clear.
        if (rise) begin
            d.rif = 1'b1;
        end
        if (fall) begin
            d.fif = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '{md: cmp_ctl_pkg::mode_reset, default: '0};
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign avs_waitrequest = avs_read & ~q.rd_done;
    assign avs_readdata    = q.rdata;
    assign avs_response    = q.resp;
    assign cmp_power_on    = q.en;
    assign cmp_resp_mode   = q.md;
    assign pos_hyst_sel    = q.hyp;
    assign neg_hyst_sel    = q.hyn;
    // Raw path is pure gating so it works with no clock running.
    assign cmp_raw_out     = cmp_core_out & q.en;
    assign cmp_latched_out = q.sync2 & q.en;
    assign cmp_irq         = (q.rif & q.rie) | (q.fif & q.fie);
    assign cmp_reset_src   = q.sync2 & q.en;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_rise_sets_flag: assert property (
        (q.en && $rose(q.sync2)) |=> q.rif)
        else $error("rising edge did not set flag");
    a_fall_sets_flag: assert property (
        (q.en && $fell(q.sync2)) |=> q.fif)
        else $error("falling edge did not set flag");
    a_flag_sticky: assert property (
        (q.rif && !(avs_write && hit_ctrl)) |=> q.rif)
        else $error("rising flag cleared without write");
    a_irq_rise_gate: assert property (
        (q.rif && !q.rie && !(q.fif && q.fie)) |-> !cmp_irq)
        else $error("interrupt without rising enable");
    a_irq_fall_gate: assert property (
        (q.fif && q.fie) |-> cmp_irq)
        else $error("falling flag enabled but no interrupt");
    a_off_forces_low: assert property (
        !q.en |-> (!cmp_latched_out && !cmp_raw_out && !cmp_power_on))
        else $error("disabled comparator drives output");
    a_sync_two_stage: assert property (
        q.en ##0 $stable(q.en)[*3] |-> q.sync2 == $past(cmp_core_out, 2))
        else $error("latched output not two cycles behind");
    a_enable_write: assert property (
        (avs_write && hit_ctrl && avs_byteenable[0]) |=>
            q.en == $past(avs_writedata[7]))
        else $error("enable bit did not follow write");
    a_mode_write: assert property (
        (avs_write && hit_mode && avs_byteenable[0]) |=>
            cmp_resp_mode == $past(avs_writedata[1:0]))
        else $error("mode field did not follow write");

    c_rise_irq: cover property (q.rif && q.rie && cmp_irq);
    c_fall_irq: cover property (q.fif && q.fie && cmp_irq);
    c_set_vs_clear: cover property (rise && avs_write && hit_ctrl);
    c_enable_on: cover property ($rose(q.en));

endmodule // cmp_ctl

`default_nettype wire

// [cmp_ctl_pkg.sv]
// Purpose: Constants for the comparator control and status logic.
// Assumes: Avalon-MM register access with 32-bit data, 100 MHz clock.
// Notes:   Registers are one aligned word each; data in bits 7:0.
// Functional notes
// - Offer a clock-synchronised latched output and a raw unsampled output.
// - Raw output follows the comparator even with the clock stopped.
// - While disabled, pin output is forced low and comparator power is off.
// - Result is readable, usable as interrupt source and routable to a pin.
// - Software sets a response mode; slower mode lowers supply current.
// - Hysteresis sits in control bits 3:0 as positive and negative fields.
// - Negative field selects disabled, 5, 10 or 20 mV as a code.
// - Positive field selects from the same four settings.
// - Each falling output transition sets the falling-edge flag.
// - Each rising output transition sets the rising-edge flag.
// - Edge flags stay set; only a software write of 0 clears them.
// - Rising flag requests an interrupt only while its enable is 1.
// - Falling flag requests an interrupt only while its enable is 1.
// - Read-only level bit returns the present output without side effects.
// - Enable bit written 1 turns the comparator on, 0 turns it off.
// - Comparator result is offered to the reset logic as a reset source.
// - Hysteresis codes: 00 off, 01 5 mV, 10 10 mV, 11 20 mV.
// - Mode 00 fastest to 11 slowest; reset value is 10.

package cmp_ctl_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [3:0] ctrl_addr = 4'h0;
    localparam logic [3:0] mode_addr = 4'h4;

    // ==========================================================
    // Control register fields
    // ==========================================================
    localparam int en_bit    = 7;
    localparam int level_bit = 6;
    localparam int rif_bit   = 5;
    localparam int fif_bit   = 4;
    localparam int hyp_lsb   = 2;
    localparam int hyn_lsb   = 0;

    // ==========================================================
    // Mode register fields
    // ==========================================================
    localparam int rie_bit = 5;
    localparam int fie_bit = 4;
    localparam int md_lsb  = 0;

    // ==========================================================
    // Reset values and codes
    // ==========================================================
    localparam logic [1:0] mode_reset = 2'h2;
    localparam logic [1:0] hyst_off   = 2'h0;
    localparam logic [1:0] hyst_5mv   = 2'h1;
    localparam logic [1:0] hyst_10mv  = 2'h2;
    localparam logic [1:0] hyst_20mv  = 2'h3;

endpackage

// [cmp_core_model.sv]
// Purpose: Behavioural analog comparator core for the bench.
// Assumes: The bench sets the compared input level.
// Notes:   Output is low while the core has no power.
`timescale 1ns/1ps
`default_nettype none

module cmp_core_model (
    // Control
    input  wire logic power_on,
    input  wire logic in_level,
    // Result
    output logic      core_out
);
    // An unpowered core cannot drive its output high.
    assign core_out = power_on & in_level;
endmodule // cmp_core_model

`default_nettype wire

// [tb_top.sv]
// Purpose: Self-checking bench for the comparator control logic.
// Assumes: Read data stands at the edge where waitrequest is seen low.
// Notes:   Offsets 0x0 control, 0x4 mode, 0x8 unmapped.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // ==========================================
    // Signals
    // ==========================================
    logic        clk = 1'b0;
    logic        clk_run = 1'b1;
    logic        nrst = 1'b0;
    logic [3:0]  address = 4'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  response;
    logic        lvl = 1'b0;
    logic        core_out, power_on, raw_out, latched, irq, rst_src;
    logic [1:0]  resp_mode, pos_hyst, neg_hyst;
    int          errors = 0;
    int          num_checks = 0;

    always #5 if (clk_run) clk = ~clk;

    cmp_ctl cmp_ctl_inst (.clk(clk), .nrst(nrst), .avs_address(address),
        .avs_read(read), .avs_write(write), .avs_writedata(writedata),
        .avs_byteenable(4'hf), .avs_readdata(readdata),
        .avs_waitrequest(waitrequest), .avs_response(response),
        .cmp_core_out(core_out), .cmp_power_on(power_on),
        .cmp_resp_mode(resp_mode), .pos_hyst_sel(pos_hyst),
        .neg_hyst_sel(neg_hyst), .cmp_latched_out(latched),
        .cmp_raw_out(raw_out), .cmp_irq(irq), .cmp_reset_src(rst_src));
    cmp_core_model cmp_core_model_inst (.power_on(power_on),
        .in_level(lvl), .core_out(core_out));

    // ==========================================
    // Tasks
    // ==========================================
    task automatic chk(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic ok;
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do begin
            @(negedge clk);
            ok = (waitrequest === 1'b0);
            @(posedge clk);
        end while (!ok);
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e,
                      input logic [1:0] r);
        logic        ok;
        logic [31:0] data;
        logic [1:0]  resp;
        address <= a;
        read <= 1'b1;
        do begin
            @(negedge clk);
            ok = (waitrequest === 1'b0);
            data = readdata;
            resp = response;
            @(posedge clk);
        end while (!ok);
        read <= 1'b0;
        @(posedge clk);
        chk("readdata", data, e);
        chk("response", {30'h0, resp}, {30'h0, r});
    endtask

    task automatic results();
        if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========================================
    // Tests
    // ==========================================
    initial begin
        #200000;
        errors++;
        results();
    end

    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(4'h0, 32'h0, 2'h0);
        rd(4'h4, 32'h2, 2'h0);
        for (int i = 0; i < 4; i++) begin
            wr(4'h0, 32'(i * 4 + 3 - i));
            chk("hyst", {28'h0, pos_hyst, neg_hyst}, 32'(i * 4 + 3 - i));
            wr(4'h4, 32'(i));
            chk("mode", {30'h0, resp_mode}, 32'(i));
        end
        wr(4'h4, 32'h0);
        lvl <= 1'b1;
        wr(4'h0, 32'h80);
        chk("power", {31'h0, power_on}, 32'h1);
        chk("raw", {31'h0, raw_out}, 32'h1);
        repeat (4) @(posedge clk);
        chk("latched", {31'h0, latched}, 32'h1);
        chk("rst_src", {31'h0, rst_src}, 32'h1);
        rd(4'h0, 32'he0, 2'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(4'h4, 32'h20);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(4'h0, 32'h80);
        rd(4'h0, 32'hc0, 2'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        lvl <= 1'b0;
        repeat (4) @(posedge clk);
        rd(4'h0, 32'h90, 2'h0);
        rd(4'h0, 32'h90, 2'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(4'h4, 32'h10);
        chk("irq", {31'h0, irq}, 32'h1);
        clk_run <= 1'b0;
        lvl <= 1'b1;
        #20;
        chk("raw", {31'h0, raw_out}, 32'h1);
        clk_run <= 1'b1;
        @(posedge clk);
        wr(4'h0, 32'h0);
        chk("power", {31'h0, power_on}, 32'h0);
        chk("raw", {31'h0, raw_out}, 32'h0);
        chk("latched", {31'h0, latched}, 32'h0);
        rd(4'h8, 32'h0, 2'h2);
        results();
    end
endmodule // tb_top

`default_nettype wire
